// ==== hdl/nsx_regs.svh ====
// constants for the nibble, skip, table and exclusive-or execution unit
`ifndef NSX_REGS_SVH
`define NSX_REGS_SVH
`define NSX_ZERO_BYTE 8'h00
`define NSX_LO_NIB 3:0
`define NSX_HI_NIB 7:4
`define NSX_FLAG_Z 0
`define NSX_FLAGS_RST 8'h00
`define NSX_ACCUMULATOR_RST 8'h00
`define NSX_LATCH_RST 8'h00
`define NSX_STROBE_RST 1'b0
`define NSX_ADDR_RST 16'h0000
`define NSX_OPC_NONE 4'h0
`define NSX_OPC_SWAP 4'h1
`define NSX_OPC_SWAP_ACCUM 4'h2
`define NSX_OPC_SZB 4'h3
`define NSX_OPC_COPY_SKIP 4'h4
`define NSX_OPC_SZBIT 4'h5
`define NSX_OPC_TRC 4'h6
`define NSX_OPC_TRL 4'h7
`define NSX_OPC_XRA 4'h8
`define NSX_OPC_XRM 4'h9
`define NSX_OPC_XRI 4'ha
`endif

// ==== hdl/nsx_pkg.sv ====
// types for the nibble, skip, table and exclusive-or execution unit
package nsx_pkg;
    typedef enum logic [1:0] {
        NSX_IDLE = 2'b00,
        NSX_DUMMY = 2'b01,
        NSX_TABLE = 2'b10
    } nsx_state_type;
endpackage

// ==== hdl/nsx_alu.sv ====
// combinational result and skip decode for the execution unit
`timescale 1ns/1ns
`include "nsx_regs.svh"
module nsx_alu
    import nsx_pkg::*;
#(
    parameter int DW = 8
) (
    input wire logic [3:0] op_i,
    input wire logic [DW-1:0] mem_i,
    input wire logic [DW-1:0] accumulator_i,
    input wire logic [DW-1:0] imm_i,
    input wire logic [2:0] bit_sel_i,
    output logic [DW-1:0] swap_o,
    output logic [DW-1:0] xor_o,
    output logic skip_o
);
    wire logic [DW-1:0] xor_src;
    wire logic sel_bit;
    // nibble exchange of the memory operand
    assign swap_o = {mem_i[`NSX_LO_NIB], mem_i[`NSX_HI_NIB]};
    // immediate form uses the code operand in place of memory
    assign xor_src = (op_i == `NSX_OPC_XRI) ? imm_i : mem_i;
    assign xor_o = accumulator_i ^ xor_src;
    assign sel_bit = mem_i[bit_sel_i];
    // skip when the tested byte or bit is zero
    assign skip_o = ((op_i == `NSX_OPC_SZB || op_i == `NSX_OPC_COPY_SKIP)
                     && mem_i == `NSX_ZERO_BYTE)
                  || (op_i == `NSX_OPC_SZBIT && !sel_bit);
endmodule

// ==== hdl/nsx_core.sv ====
// execution unit for nibble exchange, zero skips, table reads and exclusive-or
`timescale 1ns/1ns
`include "nsx_regs.svh"
module nsx_core
    import nsx_pkg::*;
#(
    parameter int DW = 8,
    parameter int PW = 8,
    parameter int PAW = 16,
    parameter logic [PW-1:0] LAST_PAGE = 8'hff
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic op_valid_i,
    input wire logic [3:0] op_code_i,
    input wire logic [DW-1:0] mem_rdata_i,
    input wire logic [DW-1:0] imm_i,
    input wire logic [2:0] bit_sel_i,
    input wire logic [PW-1:0] table_pointer_low_i,
    input wire logic [PW-1:0] table_pointer_high_i,
    input wire logic [2*DW-1:0] prog_rdata_i,
    input wire logic [DW-1:0] flags_i,
    output logic busy_o,
    output logic done_o,
    output logic skip_o,
    output logic mem_we_o,
    output logic [DW-1:0] mem_wdata_o,
    output logic accumulator_we_o,
    output logic [DW-1:0] accumulator_o,
    output logic flags_we_o,
    output logic [DW-1:0] flags_o,
    output logic prog_re_o,
    output logic [PAW-1:0] prog_addr_o,
    output logic [DW-1:0] table_high_byte_latch_o
);

    // slot state of the execution unit
    nsx_state_type state_q;
    nsx_state_type state_d;

    // output registers; each port is a plain copy of one of these
    logic busy_q;
    logic done_q;
    logic skip_q;
    logic mem_we_q;
    logic [DW-1:0] mem_wdata_q;
    logic accumulator_we_q;
    logic [DW-1:0] accumulator_q;
    logic flags_we_q;
    logic [DW-1:0] flags_q;
    logic prog_re_q;
    logic [PAW-1:0] prog_addr_q;
    logic [DW-1:0] latch_q;

    // next values of the output registers
    wire logic busy_d;
    wire logic done_d;
    wire logic skip_d;
    wire logic mem_we_d;
    wire logic [DW-1:0] mem_wdata_d;
    wire logic accumulator_we_d;
    wire logic [DW-1:0] accumulator_d;
    wire logic flags_we_d;
    wire logic [DW-1:0] flags_d;
    wire logic prog_re_d;
    wire logic [PAW-1:0] prog_addr_d;
    wire logic [DW-1:0] latch_d;

    // results from the combinational operand path
    wire logic [DW-1:0] swap_w;
    wire logic [DW-1:0] xor_w;
    wire logic skip_w;

    // decode of the presented instruction and of the current slot
    wire logic take;
    wire logic in_dummy;
    wire logic in_table;
    wire logic is_skip;
    wire logic is_table;
    wire logic is_xor;
    wire logic skip_now;
    wire logic zero_res;
    wire logic [DW-1:0] mem_src;
    wire logic [DW-1:0] accumulator_src;
    wire logic [DW-1:0] flags_z;
    wire logic [PAW-1:0] tbl_addr;

    // opcode classes; the slot machine asks the skip and table ones, the strobe decode all three
    function automatic logic op_is_skip(input logic [3:0] op);
        op_is_skip = op == `NSX_OPC_SZB || op == `NSX_OPC_COPY_SKIP
                     || op == `NSX_OPC_SZBIT;
    endfunction

    function automatic logic op_is_table(input logic [3:0] op);
        op_is_table = op == `NSX_OPC_TRC || op == `NSX_OPC_TRL;
    endfunction

    function automatic logic op_is_xor(input logic [3:0] op);
        op_is_xor = op == `NSX_OPC_XRA || op == `NSX_OPC_XRM || op == `NSX_OPC_XRI;
    endfunction

    // the in-place forms write the byte back to data memory
    function automatic logic op_writes_mem(input logic [3:0] op);
        op_writes_mem = op == `NSX_OPC_SWAP || op == `NSX_OPC_XRM;
    endfunction

    // forms that leave their result in the accumulator
    function automatic logic op_writes_accumulator(input logic [3:0] op);
        op_writes_accumulator = op == `NSX_OPC_SWAP_ACCUM || op == `NSX_OPC_COPY_SKIP
                                || op == `NSX_OPC_XRA || op == `NSX_OPC_XRI;
    endfunction

    // operand path: nibble swap, exclusive-or and zero tests
    nsx_alu #(.DW(DW)) u_alu (
        .op_i(op_code_i),
        .mem_i(mem_rdata_i),
        .accumulator_i(accumulator_q),
        .imm_i(imm_i),
        .bit_sel_i(bit_sel_i),
        .swap_o(swap_w),
        .xor_o(xor_w),
        .skip_o(skip_w)
    );

    // an instruction is taken only in the idle slot; busy slots ignore valid
    assign take = op_valid_i && state_q == NSX_IDLE;
    assign in_dummy = state_q == NSX_DUMMY;
    assign in_table = state_q == NSX_TABLE;
    assign is_skip = op_is_skip(op_code_i);
    assign is_table = op_is_table(op_code_i);
    assign is_xor = op_is_xor(op_code_i);
    // a failed test costs no slot, so only a real skip enters the dummy slot
    assign skip_now = take && is_skip && skip_w;

    // the last page ignores the high pointer and uses the fixed top page
    assign tbl_addr = (op_code_i == `NSX_OPC_TRL) ?
                      PAW'({LAST_PAGE, table_pointer_low_i}) :
                      PAW'({table_pointer_high_i, table_pointer_low_i});

    // only the zero bit follows the result; every other flag passes through
    assign zero_res = xor_w == `NSX_ZERO_BYTE;
    generate
        for (genvar gi = 0; gi < DW; gi++) begin : g_flag
            if (gi == `NSX_FLAG_Z) begin : g_zero
                assign flags_z[gi] = zero_res;
            end else begin : g_keep
                assign flags_z[gi] = flags_i[gi];
            end
        end
    endgenerate

    // operand sources for the two write ports
    assign mem_src = in_table ? prog_rdata_i[DW-1:0] :
                     (op_code_i == `NSX_OPC_XRM) ? xor_w : swap_w;
    assign accumulator_src = (op_code_i == `NSX_OPC_SWAP_ACCUM) ? swap_w :
                             (op_code_i == `NSX_OPC_COPY_SKIP) ? mem_rdata_i :
                             xor_w;

    // strobes for the cycle after the take, or for the second slot
    assign busy_d = state_d != NSX_IDLE;
    assign done_d = in_table || in_dummy || (take && !is_table && !skip_now);
    assign skip_d = skip_now;
    assign mem_we_d = in_table || (take && op_writes_mem(op_code_i));
    assign accumulator_we_d = take && op_writes_accumulator(op_code_i);
    // flags are written by the exclusive-or forms alone
    assign flags_we_d = take && is_xor;
    assign prog_re_d = take && is_table;

    // held values change only together with their strobe
    assign mem_wdata_d = mem_we_d ? mem_src : mem_wdata_q;
    assign accumulator_d = accumulator_we_d ? accumulator_src : accumulator_q;
    assign flags_d = flags_we_d ? flags_z : flags_q;
    assign prog_addr_d = prog_re_d ? tbl_addr : prog_addr_q;
    // program word is taken in the table slot, while the address is on the port
    assign latch_d = in_table ? prog_rdata_i[2*DW-1:DW] : latch_q;

    // skip ops that skip spend a dummy slot, table reads a fetch slot
    always_comb begin
        state_d = state_q;
        case (state_q)
            NSX_IDLE: begin
                if (skip_now) begin
                    state_d = NSX_DUMMY;
                end else if (take && is_table) begin
                    state_d = NSX_TABLE;
                end
            end
            NSX_DUMMY: begin
                state_d = NSX_IDLE;
            end
            NSX_TABLE: begin
                state_d = NSX_IDLE;
            end
            default: begin
                state_d = NSX_IDLE;
            end
        endcase
    end

    // slot register
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= NSX_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // one-cycle strobes; they fall by themselves on the following edge
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            busy_q <= `NSX_STROBE_RST;
            done_q <= `NSX_STROBE_RST;
            skip_q <= `NSX_STROBE_RST;
        end else begin
            busy_q <= busy_d;
            done_q <= done_d;
            skip_q <= skip_d;
        end
    end

    // write strobes towards memory, accumulator and flags, and the program read strobe
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mem_we_q <= `NSX_STROBE_RST;
            accumulator_we_q <= `NSX_STROBE_RST;
            flags_we_q <= `NSX_STROBE_RST;
            prog_re_q <= `NSX_STROBE_RST;
        end else begin
            mem_we_q <= mem_we_d;
            accumulator_we_q <= accumulator_we_d;
            flags_we_q <= flags_we_d;
            prog_re_q <= prog_re_d;
        end
    end

    // data byte written back to memory
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mem_wdata_q <= `NSX_ZERO_BYTE;
        end else begin
            mem_wdata_q <= mem_wdata_d;
        end
    end

    // accumulator copy; it also feeds the exclusive-or operand
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            accumulator_q <= `NSX_ACCUMULATOR_RST;
        end else begin
            accumulator_q <= accumulator_d;
        end
    end

    // flag byte offered with the flag write strobe
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flags_q <= `NSX_FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    // program address, held after the fetch for the memory to use
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prog_addr_q <= `NSX_ADDR_RST;
        end else begin
            prog_addr_q <= prog_addr_d;
        end
    end

    // table high-byte latch keeps the upper half of the last word read
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            latch_q <= `NSX_LATCH_RST;
        end else begin
            latch_q <= latch_d;
        end
    end

    // ports are plain copies of the registers, so every output comes from a flop
    assign busy_o = busy_q;
    assign done_o = done_q;
    assign skip_o = skip_q;
    assign mem_we_o = mem_we_q;
    assign mem_wdata_o = mem_wdata_q;
    assign accumulator_we_o = accumulator_we_q;
    assign accumulator_o = accumulator_q;
    assign flags_we_o = flags_we_q;
    assign flags_o = flags_q;
    assign prog_re_o = prog_re_q;
    assign prog_addr_o = prog_addr_q;
    assign table_high_byte_latch_o = latch_q;
endmodule

// ==== testbench/nsx_core_props.sv ====
// port-level assertions for the execution unit
`timescale 1ns/1ns
module nsx_core_props (
    input logic clk_sys_i,
    input logic sys_rst_i,
    input logic op_valid_i,
    input logic [3:0] op_code_i,
    input logic [7:0] mem_rdata_i,
    input logic [2:0] bit_sel_i,
    input logic busy_o,
    input logic done_o,
    input logic skip_o,
    input logic mem_we_o,
    input logic [7:0] mem_wdata_o,
    input logic accumulator_we_o,
    input logic [7:0] accumulator_o,
    input logic flags_we_o,
    input logic [7:0] flags_o,
    input logic prog_re_o
);
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);
    // take edge and the nibble-swapped operand
    logic take;
    logic [7:0] sw;
    assign take = op_valid_i && !busy_o;
    assign sw = {mem_rdata_i[3:0], mem_rdata_i[7:4]};
    AST_SWAP: assert property (
        take && op_code_i == 4'h1 |=> mem_we_o && mem_wdata_o == $past(sw)) else $error("swap");
    AST_SWAP_ACCUM: assert property (
        take && op_code_i == 4'h2 |=> !mem_we_o && accumulator_o == $past(sw))
        else $error("swap to accumulator");
    AST_SKIP: assert property (
        take && op_code_i == 4'h3 && mem_rdata_i == 8'h00 |=> skip_o && busy_o ##1 done_o)
        else $error("skip");
    AST_NOSKIP: assert property (
        take && op_code_i == 4'h3 && mem_rdata_i != 8'h00 |=> done_o && !skip_o)
        else $error("noskip");
    AST_COPY: assert property (
        take && op_code_i == 4'h4 |=> accumulator_o == $past(mem_rdata_i)
        && skip_o == (accumulator_o == 8'h00)) else $error("copy");
    AST_BIT: assert property (
        take && op_code_i == 4'h5 |=> skip_o == !$past(mem_rdata_i[bit_sel_i])) else $error("bit");
    AST_FLAGS: assert property (
        take && op_code_i inside {[4'h1:4'h7]} |=> !flags_we_o) else $error("flags");
    AST_TABLE: assert property (
        take && op_code_i == 4'h6 |=> prog_re_o ##1 mem_we_o && done_o) else $error("table");
    AST_XACC: assert property (
        take && op_code_i inside {4'h8, 4'ha} |=> accumulator_we_o && flags_we_o
        && flags_o[0] == (accumulator_o == 8'h00)) else $error("xor accumulator");
    AST_XMEM: assert property (
        take && op_code_i == 4'h9 |=> mem_we_o && flags_we_o
        && mem_wdata_o == ($past(mem_rdata_i) ^ accumulator_o)) else $error("xor mem");
endmodule

// ==== testbench/nibble_skip_table_xor_ops_test.sv ====
// self-checking bench for the nibble, skip, table and xor unit
`timescale 1ns/1ns
module nibble_skip_table_xor_ops_test;
    logic clk_sys_i = 0, sys_rst_i = 1, op_valid_i = 0, busy_o, done_o, skip_o, mem_we_o;
    logic accumulator_we_o, flags_we_o, prog_re_o;
    logic [3:0] op_code_i = 4'h0;
    logic [2:0] bit_sel_i = 3'h0;
    logic [7:0] mem_rdata_i = 8'h00, imm_i = 8'h00, flags_i = 8'h80, mem_wdata_o, flags_o;
    logic [7:0] table_pointer_low_i = 8'h00, table_pointer_high_i = 8'h00;
    logic [7:0] accumulator_o, table_high_byte_latch_o;
    logic [15:0] prog_rdata_i = 16'h0000, prog_addr_o;
    int err_count = 0, checks = 0, cycles = 0;
    nsx_core u_dut (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .op_valid_i(op_valid_i),
        .op_code_i(op_code_i),
        .mem_rdata_i(mem_rdata_i),
        .imm_i(imm_i),
        .bit_sel_i(bit_sel_i),
        .table_pointer_low_i(table_pointer_low_i),
        .table_pointer_high_i(table_pointer_high_i),
        .prog_rdata_i(prog_rdata_i),
        .flags_i(flags_i),
        .busy_o(busy_o),
        .done_o(done_o),
        .skip_o(skip_o),
        .mem_we_o(mem_we_o),
        .mem_wdata_o(mem_wdata_o),
        .accumulator_we_o(accumulator_we_o),
        .accumulator_o(accumulator_o),
        .flags_we_o(flags_we_o),
        .flags_o(flags_o),
        .prog_re_o(prog_re_o),
        .prog_addr_o(prog_addr_o),
        .table_high_byte_latch_o(table_high_byte_latch_o)
    );
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // hang guard: the run needs well under a hundred cycles
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 500) begin
            err_count++;
            results();
        end
    end
    task automatic chk(input logic [16:0] g, input logic [16:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // a gap edge first, so valid never falls and rises in one time step
    // a busy slot refuses requests, so wait for it to end first
    task automatic go(input logic [3:0] c, input logic [7:0] m);
        @(negedge clk_sys_i);
        while (busy_o) @(negedge clk_sys_i);
        op_code_i = c;
        mem_rdata_i = m;
        op_valid_i = 1;
        @(negedge clk_sys_i);
        op_valid_i = 0;
    endtask
    task automatic t_nib();
        go(4'h0, 8'hff);
        chk({done_o, skip_o, mem_we_o, accumulator_we_o, flags_we_o, prog_re_o}, 6'h20);
        go(4'h1, 8'h3c);
        chk({mem_we_o, mem_wdata_o, flags_we_o}, 10'h386);
        go(4'h2, 8'ha5);
        chk({mem_we_o, accumulator_o}, 9'h05a);
    endtask
    task automatic t_skip();
        go(4'h3, 8'h00);
        chk({skip_o, busy_o}, 2'h3);
        @(negedge clk_sys_i);
        chk({done_o, busy_o}, 2'h2);
        go(4'h3, 8'h01);
        chk({skip_o, done_o}, 2'h1);
        go(4'h4, 8'h00);
        chk({skip_o, accumulator_o}, 9'h100);
        bit_sel_i = 3'h3;
        go(4'h5, 8'hf7);
        chk(skip_o, 1'b1);
        go(4'h5, 8'h08);
        chk({skip_o, done_o}, 2'h1);
    endtask
    task automatic t_tbl();
        table_pointer_high_i = 8'h12;
        table_pointer_low_i = 8'h34;
        go(4'h6, 8'h00);
        chk({prog_re_o, prog_addr_o}, 17'h11234);
        prog_rdata_i = 16'hbeef;
        @(negedge clk_sys_i);
        chk({mem_we_o, mem_wdata_o, table_high_byte_latch_o}, 17'h1efbe);
        go(4'h7, 8'h00);
        chk(prog_addr_o, 16'hff34);
        prog_rdata_i = 16'h5aa5;
        @(negedge clk_sys_i);
        chk({mem_wdata_o, table_high_byte_latch_o}, 16'ha55a);
    endtask
    task automatic t_xor();
        go(4'h4, 8'h55);
        go(4'h8, 8'h55);
        chk({flags_we_o, flags_o, accumulator_o}, 17'h18100);
        go(4'h9, 8'h0f);
        chk({mem_we_o, mem_wdata_o, flags_o}, 17'h10f80);
        imm_i = 8'h3c;
        go(4'ha, 8'h00);
        chk({accumulator_we_o, flags_o, accumulator_o}, 17'h1803c);
    endtask
    task automatic results();
        if (err_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk_sys_i);
        sys_rst_i = 0;
        t_nib();
        t_skip();
        t_tbl();
        t_xor();
        results();
    end
endmodule
bind nsx_core nsx_core_props u_props (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .op_valid_i(op_valid_i),
    .op_code_i(op_code_i),
    .mem_rdata_i(mem_rdata_i),
    .bit_sel_i(bit_sel_i),
    .busy_o(busy_o),
    .done_o(done_o),
    .skip_o(skip_o),
    .mem_we_o(mem_we_o),
    .mem_wdata_o(mem_wdata_o),
    .accumulator_we_o(accumulator_we_o),
    .accumulator_o(accumulator_o),
    .flags_we_o(flags_we_o),
    .flags_o(flags_o),
    .prog_re_o(prog_re_o)
);
